// [verilog/hfs_pkg.sv]
// Package of constants and types for the hotswap fault supervisor
package hfs_pkg;

  // ----------------------------------------------------------------
  // APB register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HFS_SETUP_ADDR = 8'h00;
  localparam logic [7:0] HFS_MASK_ADDR = 8'h04;
  localparam logic [7:0] HFS_STATUS_ADDR = 8'h08;
  localparam logic [7:0] HFS_STATE_ADDR = 8'h0C;

  // ----------------------------------------------------------------
  // Setup register fields
  // ----------------------------------------------------------------
  localparam int HFS_RETRY_BIT = 0;
  localparam int HFS_FAST_BIT = 1;
  localparam int HFS_GP1_LSB = 2;
  localparam int HFS_GP2_LSB = 4;
  localparam int HFS_GPO1_BIT = 6;
  localparam int HFS_GPO2_BIT = 7;
  localparam logic [7:0] HFS_SETUP_RST = 8'h00;
  localparam logic [9:0] HFS_MASK_RST = 10'h000;

  // ----------------------------------------------------------------
  // Fault indices (status and mask bit positions)
  // ----------------------------------------------------------------
  localparam int HFS_F_OT = 0;
  localparam int HFS_F_CB = 1;
  localparam int HFS_F_SC = 2;
  localparam int HFS_F_SPF = 3;
  localparam int HFS_F_CURRENT_MONITOR_PIN_OPEN = 4;
  localparam int HFS_F_CURRENT_REFERENCE_PIN = 5;
  localparam int HFS_F_SUTMR = 6;
  localparam int HFS_F_GS = 7;
  localparam int HFS_F_DS = 8;
  localparam int HFS_F_EXT = 9;
  localparam int HFS_NFAULT = 10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HFS_CLK_MHZ = 25;
  localparam int HFS_CURRENT_MONITOR_PIN_SHORT_US = 45;
  localparam int HFS_GS_US = 10;
  localparam int HFS_CURRENT_MONITOR_PIN_SHORT_CYC = HFS_CURRENT_MONITOR_PIN_SHORT_US * HFS_CLK_MHZ;
  localparam int HFS_GS_CYC = HFS_GS_US * HFS_CLK_MHZ;
  localparam int HFS_CNT_W = 16;

  // ----------------------------------------------------------------
  // Supervisor states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HFS_OFF = 3'b000,
    HFS_START = 3'b001,
    HFS_ON = 3'b010,
    HFS_LATCHED = 3'b011,
    HFS_RETRY = 3'b100,
    HFS_FAST = 3'b101
  } hfs_state_t;

endpackage

// [verilog/hfs_delay.sv]
// Qualify delay: output rises after input held for a cycle count
`timescale 1ns/100ps
module hfs_delay
  import hfs_pkg::*;
#(
  parameter int COUNT = 1
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Condition
  input wire logic cond,
  output logic done
);

  logic [HFS_CNT_W-1:0] count;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (!cond)
      count <= '0;
    else if (count != HFS_CNT_W'(COUNT))
      count <= count + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done <= 1'b0;
    else
      done <= cond && (count == HFS_CNT_W'(COUNT - 1));
  end

endmodule // hfs_delay

// [verilog/hfs_supervisor.sv]
// Fault supervisor top: detection, latching, retry, indication, APB
//
// Notes on behaviour
// - Open monitor pin reads above reference: trip circuit breaker regardless of load.
// - Backup overcurrent with monitor detection failing latches single point fault.
// - Shorted monitor pin, backup exceeded 45us: latched maskable shutdown.
// - Reference too high, backup overcurrent, primary silent: single point fault.
// - Reference shorted to ground gives zero threshold: limit or trip.
// - Two general pins, function chosen by setup register bits.
// - Fast recovery short circuit: trip, limited restart, no latch, pin high.
// - Gate-source FET fault: latched, maskable, indicated after 10us.
// - Drain-source FET fault: shutdown, pin low maskable, not latched.
// - Switch enable pulled low externally without UV or OV: latched fault.
// - Open reference, backup exceeded for overcurrent timer: latched shutdown.
// - After a latched fault follow latch-off or auto-retry per retry_select.
// - Auto-retry: latched fault starts retry timer, fault pin held low.
// - Retry expiry releases fault pin and readies automatic restart.
// - Automatic restart runs normal slew-limited startup.
// - short_fast_recover: short turns off fast, restarts limited, no timer.
// - Supply cycle or enable below shutdown clears latch, pin, timer.
// - Enable slightly below undervoltage only does not clear a latch.
// - Primary device decides fault response for the whole chain.
// - Secondary with unregistered fault pulls switch enable low, latches.
// - Mask bit set suppresses fault pin for that maskable fault.
`timescale 1ns/100ps
module hfs_supervisor
  import hfs_pkg::*;
#(
  parameter int OCT_CYC = 25000,
  parameter int RETRY_CYC = 250000,
  parameter int STARTUP_CYC = 50000,
  parameter int FASTOFF_CYC = 25
)
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparator results
  input wire logic monitor_over_ref,
  input wire logic monitor_pin_open,
  input wire logic limit_over_ref,
  input wire logic short_detect,
  input wire logic backup_over,
  input wire logic reference_pin_open,
  input wire logic over_temp,
  input wire logic fet_gs_bad,
  input wire logic fet_ds_bad,
  input wire logic gate_ready,
  // Supply and enable levels
  input wire logic supply_ok,
  input wire logic enable_above_uv,
  input wire logic enable_above_sd,
  input wire logic input_ov,
  // Chain
  input wire logic is_primary,
  input wire logic switch_enable_link_in,
  output logic switch_enable_link_out,
  output logic switch_enable_link_oe,
  // Power stage
  output logic fet_on,
  output logic current_limit_mode,
  output logic slew_start,
  // Fault pin and alert
  output logic fault_indicator_n_out,
  output logic fault_indicator_n_oe,
  output logic alert_n,
  // General pins
  input wire logic ext_memory_data_in,
  input wire logic temp_digital,
  input wire logic ext_memory_clock,
  input wire logic ext_memory_data,
  output logic general_pin_one,
  output logic general_pin_two
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] device_setup;
  logic [HFS_NFAULT-1:0] fault_pin_mask;
  logic [HFS_NFAULT-1:0] fault_status;
  hfs_state_t state;
  logic [17:0] timer;
  logic retry_select;
  logic short_fast_recover;
  logic clear_latch;
  logic in_uv_ov;
  logic running;
  logic wr_en;
  logic rd_en;
  logic [HFS_NFAULT-1:0] fault_event;
  logic [HFS_NFAULT-1:0] latched_evt;
  logic any_latch;
  logic oc_timed;
  logic oc_current_reference_pin_timed;
  logic current_monitor_pin_short_timed;
  logic gs_timed;
  logic spf_cond;
  logic current_monitor_pin_short_cond;
  logic ds_active;

  assign retry_select = device_setup[HFS_RETRY_BIT];
  assign short_fast_recover = device_setup[HFS_FAST_BIT];
  assign clear_latch = !supply_ok || !enable_above_sd;
  assign in_uv_ov = !supply_ok || !enable_above_uv || input_ov;
  assign running = (state == HFS_START) || (state == HFS_ON);

  // ----------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------
  // Primary trip: open monitor pin pulls above reference; shorted
  // reference makes limit comparator fire at any load
  hfs_delay #(.COUNT(OCT_CYC)) u_oc (
    .pclk(pclk),
    .presetn(presetn),
    .cond(running && (monitor_over_ref || limit_over_ref)),
    .done(oc_timed)
  );

  // Backup current over while primary monitor and limit stay silent
  assign spf_cond = running && backup_over && !monitor_over_ref
    && !limit_over_ref && !short_detect;
  assign current_monitor_pin_short_cond = spf_cond && !reference_pin_open;

  hfs_delay #(.COUNT(HFS_CURRENT_MONITOR_PIN_SHORT_CYC)) u_current_monitor_pin (
    .pclk(pclk),
    .presetn(presetn),
    .cond(current_monitor_pin_short_cond),
    .done(current_monitor_pin_short_timed)
  );

  hfs_delay #(.COUNT(OCT_CYC)) u_current_reference_pin (
    .pclk(pclk),
    .presetn(presetn),
    .cond(spf_cond && reference_pin_open),
    .done(oc_current_reference_pin_timed)
  );

  hfs_delay #(.COUNT(HFS_GS_CYC)) u_gs (
    .pclk(pclk),
    .presetn(presetn),
    .cond(running && fet_gs_bad),
    .done(gs_timed)
  );

  always_comb
  begin
    fault_event = '0;
    fault_event[HFS_F_OT] = running && over_temp;
    fault_event[HFS_F_CB] = oc_timed;
    fault_event[HFS_F_SC] = running && short_detect;
    fault_event[HFS_F_SPF] = current_monitor_pin_short_timed || oc_current_reference_pin_timed;
    fault_event[HFS_F_CURRENT_MONITOR_PIN_OPEN] = running && monitor_pin_open;
    fault_event[HFS_F_CURRENT_REFERENCE_PIN] = oc_current_reference_pin_timed;
    fault_event[HFS_F_SUTMR] = (state == HFS_START)
      && (timer == 18'(STARTUP_CYC));
    fault_event[HFS_F_GS] = gs_timed;
    fault_event[HFS_F_DS] = (state == HFS_START) && fet_ds_bad
      && (timer == 18'(STARTUP_CYC));
    // Own drive lags state a cycle; fet_on avoids a false trip at start
    fault_event[HFS_F_EXT] = running && fet_on && !switch_enable_link_in
      && !in_uv_ov;
  end

  // Short with fast recovery and drain-source fault never latch
  always_comb
  begin
    latched_evt = fault_event;
    latched_evt[HFS_F_DS] = 1'b0;
    if (short_fast_recover)
      latched_evt[HFS_F_SC] = 1'b0;
  end
  // Secondary with an unregistered fault latches the chain off
  assign any_latch = |latched_evt;
  assign ds_active = fet_ds_bad && !running && state != HFS_LATCHED;

  // ----------------------------------------------------------------
  // Supervisor state machine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= HFS_OFF;
      timer <= '0;
    end
    else if (clear_latch)
    begin
      state <= HFS_OFF;
      timer <= '0;
    end
    else
    begin
      unique case (state)
        HFS_OFF:
        begin
          timer <= '0;
          if (!in_uv_ov && !fet_ds_bad && (is_primary || switch_enable_link_in))
            state <= HFS_START;
        end
        HFS_START:
        begin
          timer <= timer + 1'b1;
          if (any_latch)
          begin
            state <= retry_select ? HFS_RETRY : HFS_LATCHED;
            timer <= '0;
          end
          else if (fault_event[HFS_F_SC])
          begin
            state <= HFS_FAST;
            timer <= '0;
          end
          else if (fault_event[HFS_F_DS] || in_uv_ov)
            state <= HFS_OFF;
          else if (gate_ready)
            state <= HFS_ON;
        end
        HFS_ON:
        begin
          timer <= '0;
          if (any_latch)
            state <= retry_select ? HFS_RETRY : HFS_LATCHED;
          else if (fault_event[HFS_F_SC])
            state <= HFS_FAST;
          else if (in_uv_ov)
            state <= HFS_OFF;
        end
        HFS_LATCHED:
          timer <= '0; // Only a supply or enable cycle leaves
        HFS_RETRY:
        begin
          timer <= timer + 1'b1;
          if (timer == 18'(RETRY_CYC - 1))
            state <= HFS_OFF;
        end
        HFS_FAST:
        begin
          timer <= timer + 1'b1;
          if (timer == 18'(FASTOFF_CYC - 1))
          begin
            state <= HFS_START;
            timer <= '0;
          end
        end
        default:
          state <= HFS_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power stage and chain outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fet_on <= 1'b0;
      current_limit_mode <= 1'b0;
      slew_start <= 1'b0;
      switch_enable_link_oe <= 1'b0;
    end
    else
    begin
      fet_on <= (state == HFS_START) || (state == HFS_ON);
      slew_start <= (state == HFS_START);
      if (state == HFS_FAST)
        current_limit_mode <= 1'b1;
      else if (state == HFS_ON || state == HFS_OFF)
        current_limit_mode <= 1'b0;
      // Drive low whenever off; high drive only when switch on
      switch_enable_link_oe <= 1'b1;
    end
  end
  assign switch_enable_link_out = fet_on;

  // ----------------------------------------------------------------
  // Status flags and fault pin
  // ----------------------------------------------------------------
  // Set wins over clear by host write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_status <= '0;
    else if (clear_latch)
      fault_status <= '0;
    else if (wr_en && paddr == HFS_STATUS_ADDR)
      fault_status <= (fault_status & ~pwdata[HFS_NFAULT-1:0])
        | fault_event;
    else
      fault_status <= fault_status | fault_event;
  end

  logic pin_low;
  always_comb
  begin
    pin_low = 1'b0;
    if (state == HFS_LATCHED || state == HFS_RETRY)
      pin_low = |(fault_status & ~fault_pin_mask)
        || fault_status[HFS_F_SUTMR];
    if (ds_active && !fault_pin_mask[HFS_F_DS])
      pin_low = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_indicator_n_oe <= 1'b0;
      alert_n <= 1'b1;
    end
    else
    begin
      fault_indicator_n_oe <= pin_low;
      alert_n <= !fault_status[HFS_F_SPF];
    end
  end
  assign fault_indicator_n_out = 1'b0;

  // ----------------------------------------------------------------
  // General pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      general_pin_one <= 1'b0;
      general_pin_two <= 1'b0;
    end
    else
    begin
      unique case (device_setup[HFS_GP1_LSB+:2])
        2'h0: general_pin_one <= temp_digital;
        2'h1: general_pin_one <= ext_memory_clock;
        default: general_pin_one <= device_setup[HFS_GPO1_BIT];
      endcase
      unique case (device_setup[HFS_GP2_LSB+:2])
        2'h0: general_pin_two <= ext_memory_data_in;
        2'h1: general_pin_two <= ext_memory_data;
        default: general_pin_two <= device_setup[HFS_GPO2_BIT];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !(paddr == HFS_SETUP_ADDR
    || paddr == HFS_MASK_ADDR || paddr == HFS_STATUS_ADDR
    || paddr == HFS_STATE_ADDR);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      device_setup <= HFS_SETUP_RST;
      fault_pin_mask <= HFS_MASK_RST;
    end
    else if (wr_en)
    begin
      if (paddr == HFS_SETUP_ADDR)
        device_setup <= pwdata[7:0];
      if (paddr == HFS_MASK_ADDR)
        fault_pin_mask <= pwdata[HFS_NFAULT-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_en)
    begin
      unique case (paddr)
        HFS_SETUP_ADDR: prdata <= {24'h000000, device_setup};
        HFS_MASK_ADDR: prdata <= {22'h000000, fault_pin_mask};
        HFS_STATUS_ADDR: prdata <= {22'h000000, fault_status};
        HFS_STATE_ADDR: prdata <= {27'h0000000, fet_on, state,
          !fault_indicator_n_oe};
        default: prdata <= '0;
      endcase
    end
  end

endmodule // hfs_supervisor

// [verif/hfs_supervisor_chk.sv]
// Port-level assertions for the hotswap fault supervisor
`timescale 1ns/100ps
module hfs_supervisor_chk
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sensed conditions
  input wire logic monitor_pin_open,
  input wire logic backup_over,
  input wire logic monitor_over_ref,
  input wire logic fet_gs_bad,
  input wire logic switch_enable_link_in,
  input wire logic supply_ok,
  input wire logic input_ov,
  input wire logic enable_above_sd,
  // Responses
  input wire logic fet_on,
  input wire logic fault_indicator_n_out,
  input wire logic fault_indicator_n_oe,
  input wire logic alert_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Backup overcurrent cycles with the switch still on; a counter
  // because the bound is too long for a delay range
  logic [10:0] bkp_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bkp_cnt <= 11'h000;
    else if (!(backup_over && fet_on && !monitor_over_ref))
      bkp_cnt <= 11'h000;
    else if (bkp_cnt != 11'h4B0)
      bkp_cnt <= bkp_cnt + 11'h001;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_open_trip;
    $rose(monitor_pin_open) && fet_on |-> ##[1:64] !fet_on;
  endproperty
  property p_spf_off;
    $fell(alert_n) |-> ##[0:3] !fet_on;
  endproperty
  property p_bkp_trip;
    bkp_cnt != 11'h4B0;
  endproperty
  // FET must stay on for 8 cycles, then be off within 300 cycles of the fault
  property p_gs_delay;
    $rose(fet_gs_bad) && fet_on |-> fet_on [*8] ##[1:292] !fet_on;
  endproperty
  property p_ext_trip;
    fet_on && $fell(switch_enable_link_in) && supply_ok && !input_ov
      |-> ##[1:4] !fet_on;
  endproperty
  property p_pin_fet;
    $rose(fault_indicator_n_oe) |-> !fet_on [*2];
  endproperty
  property p_clear;
    !enable_above_sd [*3] |=> !fault_indicator_n_oe && alert_n;
  endproperty
  property p_pin_level;
    fault_indicator_n_oe |-> !fault_indicator_n_out;
  endproperty

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_open_trip: assert property (p_open_trip) else $error("no trip");
  a_spf_off: assert property (p_spf_off) else $error("alert, fet on");
  a_bkp_trip: assert property (p_bkp_trip) else $error("no backup");
  a_gs_delay: assert property (p_gs_delay) else $error("gs timing");
  a_ext_trip: assert property (p_ext_trip) else $error("no ext trip");
  a_pin_fet: assert property (p_pin_fet) else $error("pin low, on");
  a_clear: assert property (p_clear) else $error("not cleared");
  a_pin_level: assert property (p_pin_level) else $error("pin high");
  c_retry: cover property ($fell(fault_indicator_n_oe) ##[1:100] fet_on);
  c_alert: cover property ($fell(alert_n));
  c_fast: cover property ($fell(fet_on) && !fault_indicator_n_oe);
endmodule // hfs_supervisor_chk

// [verif/hfs_link_partner.sv]
// Shared switch-enable line with a paralleled secondary device
`timescale 1ns/100ps
module hfs_link_partner
(
  // Clock
  input wire logic pclk,
  // Local device drive
  input wire logic drv_out,
  input wire logic drv_oe,
  // Secondary fail-safe request
  input wire logic pull_req,
  // Resolved line
  output logic line
);
  logic pulling = 1'h0;

  // Secondary reacts a cycle late, like a real part
  always @(posedge pclk)
  begin
    pulling <= pull_req;
  end

  // Pull-low wins; a released line floats high
  assign line = pulling ? 1'h0 : (drv_oe ? drv_out : 1'h1);
endmodule // hfs_link_partner

// [verif/hfs_supervisor_tb.sv]
// Testbench for the hotswap fault supervisor
`timescale 1ns/100ps
module hfs_supervisor_tb
  import hfs_pkg::*;
  ;
  localparam int RETRY = 50;
  typedef struct packed
  {logic [8:0] f; logic [9:0] mask; logic [3:0] bi; logic pin;} hfs_row_t;
  // Fault bits: 0 open,1 backup,2 short,3 gs,4 ot,5 limit,6 ref open
  hfs_row_t rows [8] = '{'{9'h001, 10'h000, 4'h4, 1'h1},
    '{9'h002, 10'h000, 4'h3, 1'h1}, '{9'h008, 10'h000, 4'h7, 1'h1},
    '{9'h004, 10'h000, 4'h2, 1'h1}, '{9'h010, 10'h000, 4'h0, 1'h1},
    '{9'h042, 10'h000, 4'h5, 1'h1}, '{9'h020, 10'h000, 4'h1, 1'h1},
    '{9'h008, 10'h080, 4'h7, 1'h0}};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, serr, fet_on, alert_n, flt_out, flt_oe, flt_pin;
  logic [8:0] f = 9'h000;
  logic [3:0] aux = 4'h0;
  logic sup = 1'h1, en_uv = 1'h1, en_sd = 1'h1, pull = 1'h0;
  logic mon = 1'h0, gr = 1'h1, clm, slew;
  logic link, lk_out, lk_oe, gp1, gp2;
  int err_count = 0, comparisons = 0, cyc = 0;

  hfs_supervisor #(.OCT_CYC(20), .RETRY_CYC(RETRY), .STARTUP_CYC(30),
    .FASTOFF_CYC(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .monitor_over_ref(mon), .monitor_pin_open(f[0]),
    .limit_over_ref(f[5]), .short_detect(f[2]), .backup_over(f[1]),
    .reference_pin_open(f[6]), .over_temp(f[4]), .fet_gs_bad(f[3]),
    .fet_ds_bad(f[7]), .gate_ready(gr), .supply_ok(sup),
    .enable_above_uv(en_uv), .enable_above_sd(en_sd), .input_ov(f[8]),
    .is_primary(1'h1), .switch_enable_link_in(link),
    .switch_enable_link_out(lk_out), .switch_enable_link_oe(lk_oe),
    .fet_on, .current_limit_mode(clm), .slew_start(slew),
    .fault_indicator_n_out(flt_out), .fault_indicator_n_oe(flt_oe),
    .alert_n, .ext_memory_data_in(aux[3]), .temp_digital(aux[0]),
    .ext_memory_clock(aux[1]), .ext_memory_data(aux[2]),
    .general_pin_one(gp1), .general_pin_two(gp2));
  hfs_link_partner u_link (.pclk, .drv_out(lk_out), .drv_oe(lk_oe),
    .pull_req(pull), .line(link));
  // Open-drain fault pin with pull-up
  assign flt_pin = flt_oe ? flt_out : 1'h1;

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Ends once pready is high; pready is tied high, so after one cycle
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_fet(input logic lvl, input int lim);
    int n;
    n = 0;
    while (fet_on !== lvl && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("fet_on", lvl, fet_on);
  endtask

  // Enable cycle below shutdown, then back to steady state
  task automatic restart;
    f <= 9'h000;
    pull <= 1'h0;
    en_sd <= 1'h0;
    repeat (3) @(posedge pclk);
    en_sd <= 1'h1;
    wait_fet(1'h1, 100);
    repeat (10) @(posedge pclk);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    chk("pin_rst", 1'h1, flt_pin);
    apb(1'h0, HFS_SETUP_ADDR, 32'h0);
    chk("setup_rst", {24'h0, HFS_SETUP_RST}, rd);
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", 1'h1, serr);
    chk("unmapped", 32'h0, rd);
    aux <= 4'h4;
    apb(1'h1, HFS_SETUP_ADDR, 32'h5A);
    apb(1'h0, HFS_SETUP_ADDR, 32'h0);
    chk("setup", 32'h5A, rd);
    chk("gp_out", 2'h3, {gp1, gp2});
    aux <= 4'h9;
    apb(1'h1, HFS_SETUP_ADDR, 32'h0);
    repeat (3) @(posedge pclk);
    chk("gp_in", 2'h3, {gp1, gp2});
    aux <= 4'h2;
    apb(1'h1, HFS_SETUP_ADDR, 32'hA4);
    repeat (3) @(posedge pclk);
    chk("gp_alt", 2'h3, {gp1, gp2});
    foreach (rows[i])
    begin
      restart();
      apb(1'h1, HFS_MASK_ADDR, {22'h0, rows[i].mask});
      f <= rows[i].f;
      wait_fet(1'h0, 1500);
      repeat (3) @(posedge pclk);
      chk("flt_pin", !rows[i].pin, flt_pin);
      apb(1'h0, HFS_STATUS_ADDR, 32'h0);
      chk("status_bit", 1'h1, rd[rows[i].bi]);
    end
    apb(1'h1, HFS_MASK_ADDR, 32'h0);
    restart();
    f <= 9'h002;
    wait_fet(1'h0, 1500);
    f <= 9'h000;
    en_uv <= 1'h0;
    repeat (10) @(posedge pclk);
    chk("uv_hold", 1'h0, flt_pin);
    chk("alert", 1'h0, alert_n);
    en_uv <= 1'h1;
    sup <= 1'h0;
    repeat (4) @(posedge pclk);
    sup <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("pwr_clear", 2'h3, {flt_pin, alert_n});
    apb(1'h0, HFS_STATUS_ADDR, 32'h0);
    chk("status_clr", 32'h0, rd);
    apb(1'h1, HFS_SETUP_ADDR, 32'h1);
    restart();
    f <= 9'h001;
    wait_fet(1'h0, 100);
    f <= 9'h000;
    repeat (RETRY - 12) @(posedge pclk);
    chk("retry_hold", 1'h0, flt_pin);
    wait_fet(1'h1, 80);
    chk("retry_rel", 1'h1, flt_pin);
    apb(1'h1, HFS_SETUP_ADDR, 32'h3);
    restart();
    f <= 9'h004;
    wait_fet(1'h0, 100);
    chk("limit_mode", 1'h1, clm);
    f <= 9'h000;
    repeat (3) @(posedge pclk);
    chk("fast_pin", 1'h1, flt_pin);
    wait_fet(1'h1, 40);
    apb(1'h1, HFS_SETUP_ADDR, 32'h0);
    restart();
    pull <= 1'h1;
    wait_fet(1'h0, 20);
    pull <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("ext_pin", 1'h0, flt_pin);
    apb(1'h0, HFS_STATUS_ADDR, 32'h0);
    chk("ext_bit", 1'h1, rd[HFS_F_EXT]);
    // Primary detection working: breaker trip, no single point fault
    restart();
    mon <= 1'h1;
    f <= 9'h002;
    wait_fet(1'h0, 100);
    mon <= 1'h0;
    f <= 9'h000;
    apb(1'h0, HFS_STATUS_ADDR, 32'h0);
    chk("cb_only", 32'h2, rd);
    chk("no_alert", 1'h1, alert_n);
    restart();
    en_uv <= 1'h0;
    f <= 9'h080;
    repeat (4) @(posedge pclk);
    chk("ds_pin", 1'h0, flt_pin);
    en_uv <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("ds_hold", 1'h0, fet_on);
    // Start-up timeout ignores the mask
    apb(1'h1, HFS_MASK_ADDR, 32'h3FF);
    gr <= 1'h0;
    restart();
    chk("slew", 1'h1, slew);
    wait_fet(1'h0, 40);
    repeat (3) @(posedge pclk);
    chk("sutmr_pin", 1'h0, flt_pin);
    wrap_up();
  end
endmodule // hfs_supervisor_tb

bind hfs_supervisor hfs_supervisor_chk u_chk (.pclk, .presetn,
  .monitor_pin_open, .backup_over, .monitor_over_ref, .fet_gs_bad,
  .switch_enable_link_in, .supply_ok, .input_ov, .enable_above_sd,
  .fet_on, .fault_indicator_n_out, .fault_indicator_n_oe, .alert_n);
